// [bst_defs.vh]
// shared constants for the boundary scan test port
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

`define BST_IR_W 5
`define BST_IR_CAPTURE 5'h01
`define BST_IR_EXTEST 5'h00
`define BST_IR_SAMPLE 5'h01
`define BST_IR_USER_CHAIN_ONE 5'h02
`define BST_IR_USER_CHAIN_TWO 5'h03
`define BST_IR_CFG_RD 5'h04
`define BST_IR_CFG_WR 5'h05
`define BST_IR_INTEST 5'h07
`define BST_IR_USERCODE 5'h08
`define BST_IR_IDCODE 5'h09
`define BST_IR_HIGHZ 5'h0A
`define BST_IR_STARTUP_CLOCK 5'h0C
`define BST_IR_BYPASS 5'h1F

`define BST_SEL_W 3
`define BST_SEL_BYPASS 3'h0
`define BST_SEL_BOUNDARY 3'h1
`define BST_SEL_IDCODE 3'h2
`define BST_SEL_USERCODE 3'h3
`define BST_SEL_CFG_RD 3'h4
`define BST_SEL_CFG_WR 3'h5
`define BST_SEL_USER_ONE 3'h6
`define BST_SEL_USER_TWO 3'h7

`define BST_CELL_BITS 3
`define BST_CELL_IN 0
`define BST_CELL_OUT 1
`define BST_CELL_TRI 2

`define BST_WORD_W 32
`define BST_CNT_W 5
`define BST_CNT_LAST 5'h1F
`define BST_CNT_ZERO 5'h00
`define BST_CNT_ONE 5'h01

`endif

// [bst_fifo.v]
// word fifo with valid and ready on both sides
`timescale 1ns/10ps
module bst_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      // pointers wrap only for power-of-two depths
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// [bst_bsr.v]
// boundary register, three cells per io cell
`timescale 1ns/10ps
`include "bst_defs.vh"
module bst_bsr #(
  parameter NUM_IO = 4
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire capture_i,
  input wire shift_i,
  input wire update_i,
  input wire tdi_i,
  input wire extest_i,
  input wire intest_i,
  input wire highz_i,
  output wire scan_o,
  input wire [NUM_IO-1:0] pad_in_i,
  output reg [NUM_IO-1:0] pad_out_o,
  output reg [NUM_IO-1:0] pad_oe_o,
  input wire [NUM_IO-1:0] core_out_i,
  input wire [NUM_IO-1:0] core_oe_i,
  output reg [NUM_IO-1:0] core_in_o
);
  localparam NB = NUM_IO * `BST_CELL_BITS;
  reg [NUM_IO-1:0] pad_s1_q;
  reg [NUM_IO-1:0] pad_s2_q;
  reg [NB-1:0] chain_q;
  reg [NB-1:0] upd_q;
  wire [NB-1:0] cap_val;
  wire drive_bsr;

  assign scan_o = chain_q[0];
  assign drive_bsr = extest_i | intest_i;

  genvar k;
  generate
    for (k = 0; k < NUM_IO; k = k + 1) begin : g_cell
      // every cell captures all three bits, bonded or not, used or not
      assign cap_val[k*`BST_CELL_BITS+`BST_CELL_IN] = pad_s2_q[k];
      assign cap_val[k*`BST_CELL_BITS+`BST_CELL_OUT] = core_out_i[k];
      assign cap_val[k*`BST_CELL_BITS+`BST_CELL_TRI] = core_oe_i[k];

      // no io cell setting enters the scan path, so configuration never breaks it
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pad_out_o[k] <= 1'b0;
          pad_oe_o[k] <= 1'b0;
          core_in_o[k] <= 1'b0;
        end else begin
          pad_out_o[k] <= drive_bsr ? upd_q[k*`BST_CELL_BITS+`BST_CELL_OUT] : core_out_i[k];
          pad_oe_o[k] <= highz_i ? 1'b0 :
            (drive_bsr ? upd_q[k*`BST_CELL_BITS+`BST_CELL_TRI] : core_oe_i[k]);
          core_in_o[k] <= intest_i ? upd_q[k*`BST_CELL_BITS+`BST_CELL_IN] : pad_s2_q[k];
        end
      end
    end
  endgenerate

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_s1_q <= {NUM_IO{1'b0}};
      pad_s2_q <= {NUM_IO{1'b0}};
      chain_q <= {NB{1'b0}};
      upd_q <= {NB{1'b0}};
    end else begin
      pad_s1_q <= pad_in_i;
      pad_s2_q <= pad_s1_q;
      if (capture_i) begin
        chain_q <= cap_val;
      end else if (shift_i) begin
        chain_q <= {tdi_i, chain_q[NB-1:1]};
      end
      if (update_i) begin
        upd_q <= chain_q;
      end
    end
  end
endmodule

// [bst_tap.v]
// test access port: tap controller, instruction decode and data registers
// Contract
// - decode and run extest, intest, sample, bypass, idcode, usercode and highz.
// - two user scan chains, each selected by its own instruction.
// - scan behaviour ignores io cell configuration and package.
// - all io cells, bonded or not, sit in one chain as tristate bidirectionals.
// - boundary test still works after configuration.
// - extest captures internal signals routed to unused io cells and outputs.
// - user chain instructions work only once configuration is done.
// - instructions for configuration write, readback and startup clocking.
// - three boundary cells per io cell, shifted by the tap controller.
// - five bit instruction codes for extest through intest as listed.
// - usercode, idcode, highz, startup, bypass codes; highz tristates, selects bypass.
// - cell order within io cell: input, output, tristate control.
// - bypass is one flip-flop passing data downstream.
`timescale 1ns/10ps
`include "bst_defs.vh"
module bst_tap #(
  parameter NUM_IO = 4,
  parameter [31:0] ID_CODE = 32'h00000001, // arbitrary value, lsb set as required
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output wire tdo_o,
  output wire tdo_oe_o,
  input wire cfg_done_i,
  input wire [31:0] usercode_i,
  input wire [31:0] cfg_rd_data_i,
  output wire cfg_rd_take_o,
  output wire [31:0] cfg_wr_data_o,
  output wire cfg_wr_valid_o,
  input wire cfg_wr_ready_i,
  output wire cfg_in_ready_o,
  output wire startup_clk_o,
  output wire tap_reset_o,
  output wire user_sel_one_o,
  output wire user_sel_two_o,
  output wire user_tdi_o,
  output wire user_capture_o,
  output wire user_shift_o,
  output wire user_update_o,
  input wire user_tdo_one_i,
  input wire user_tdo_two_i,
  input wire [NUM_IO-1:0] pad_in_i,
  output wire [NUM_IO-1:0] pad_out_o,
  output wire [NUM_IO-1:0] pad_oe_o,
  input wire [NUM_IO-1:0] core_out_i,
  input wire [NUM_IO-1:0] core_oe_i,
  output wire [NUM_IO-1:0] core_in_o
);
  localparam [3:0] S_TLR = 4'h0;
  localparam [3:0] S_RTI = 4'h1;
  localparam [3:0] S_SEL_DR = 4'h2;
  localparam [3:0] S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR = 4'h4;
  localparam [3:0] S_EX1_DR = 4'h5;
  localparam [3:0] S_PA_DR = 4'h6;
  localparam [3:0] S_EX2_DR = 4'h7;
  localparam [3:0] S_UP_DR = 4'h8;
  localparam [3:0] S_SEL_IR = 4'h9;
  localparam [3:0] S_CAP_IR = 4'hA;
  localparam [3:0] S_SH_IR = 4'hB;
  localparam [3:0] S_EX1_IR = 4'hC;
  localparam [3:0] S_PA_IR = 4'hD;
  localparam [3:0] S_EX2_IR = 4'hE;
  localparam [3:0] S_UP_IR = 4'hF;

  // instruction to data register select; reserved codes fall to bypass
  function [`BST_SEL_W-1:0] dr_select;
    input [`BST_IR_W-1:0] ir;
    input cfg_done;
    begin
      case (ir)
        `BST_IR_EXTEST: dr_select = `BST_SEL_BOUNDARY;
        `BST_IR_SAMPLE: dr_select = `BST_SEL_BOUNDARY;
        `BST_IR_INTEST: dr_select = `BST_SEL_BOUNDARY;
        `BST_IR_IDCODE: dr_select = `BST_SEL_IDCODE;
        `BST_IR_USERCODE: dr_select = `BST_SEL_USERCODE;
        `BST_IR_CFG_RD: dr_select = `BST_SEL_CFG_RD;
        `BST_IR_CFG_WR: dr_select = `BST_SEL_CFG_WR;
        `BST_IR_USER_CHAIN_ONE: dr_select = cfg_done ? `BST_SEL_USER_ONE : `BST_SEL_BYPASS;
        `BST_IR_USER_CHAIN_TWO: dr_select = cfg_done ? `BST_SEL_USER_TWO : `BST_SEL_BYPASS;
        default: dr_select = `BST_SEL_BYPASS;
      endcase
    end
  endfunction

  // standard sixteen state sequence
  function [3:0] tap_next;
    input [3:0] st;
    input tms;
    begin
      case (st)
        S_TLR: tap_next = tms ? S_TLR : S_RTI;
        S_RTI: tap_next = tms ? S_SEL_DR : S_RTI;
        S_SEL_DR: tap_next = tms ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
        S_SH_DR: tap_next = tms ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: tap_next = tms ? S_UP_DR : S_PA_DR;
        S_PA_DR: tap_next = tms ? S_EX2_DR : S_PA_DR;
        S_EX2_DR: tap_next = tms ? S_UP_DR : S_SH_DR;
        S_UP_DR: tap_next = tms ? S_SEL_DR : S_RTI;
        S_SEL_IR: tap_next = tms ? S_TLR : S_CAP_IR;
        S_CAP_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
        S_SH_IR: tap_next = tms ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: tap_next = tms ? S_UP_IR : S_PA_IR;
        S_PA_IR: tap_next = tms ? S_EX2_IR : S_PA_IR;
        S_EX2_IR: tap_next = tms ? S_UP_IR : S_SH_IR;
        S_UP_IR: tap_next = tms ? S_SEL_DR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // test pins are asynchronous to clock_i; logic reads stage two, and stage three only for tck edges
  reg tck_s1_q;
  reg tck_s2_q;
  reg tck_s3_q;
  reg tms_s1_q;
  reg tms_s2_q;
  reg tdi_s1_q;
  reg tdi_s2_q;
  reg [3:0] st_q;
  reg [`BST_IR_W-1:0] ir_q;
  reg [`BST_IR_W-1:0] ir_sh_q;
  reg [`BST_WORD_W-1:0] dr_q;
  reg byp_q;
  reg [`BST_CNT_W-1:0] cnt_q;
  reg tdo_q;
  reg tdo_oe_q;
  reg rd_take_q;
  reg push_v_q;
  reg [`BST_WORD_W-1:0] push_d_q;
  reg dr_so;
  wire tck_rise;
  wire tck_fall;
  wire [`BST_SEL_W-1:0] sel;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;
  wire bsr_sel;
  wire bsr_so;
  wire fifo_in_rdy;
  wire word_end;
  wire user_any;

  // tck runs far below clock_i, so sampled edges stand in for its edges
  assign tck_rise = tck_s2_q & ~tck_s3_q;
  assign tck_fall = ~tck_s2_q & tck_s3_q;
  assign sel = dr_select(ir_q, cfg_done_i);
  assign cap_dr = tck_rise & (st_q == S_CAP_DR);
  assign sh_dr = tck_rise & (st_q == S_SH_DR);
  assign upd_dr = tck_fall & (st_q == S_UP_DR);
  assign bsr_sel = (sel == `BST_SEL_BOUNDARY);
  assign word_end = sh_dr & (cnt_q == `BST_CNT_LAST);
  assign user_any = (sel == `BST_SEL_USER_ONE) | (sel == `BST_SEL_USER_TWO);

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign cfg_rd_take_o = rd_take_q;
  // host should poll this before a write word; one landing while a word waits on a full fifo replaces it
  assign cfg_in_ready_o = fifo_in_rdy & ~push_v_q;
  assign startup_clk_o = tck_rise & (st_q == S_RTI) & (ir_q == `BST_IR_STARTUP_CLOCK);
  assign tap_reset_o = (st_q == S_TLR);
  assign user_sel_one_o = (sel == `BST_SEL_USER_ONE);
  assign user_sel_two_o = (sel == `BST_SEL_USER_TWO);
  assign user_tdi_o = tdi_s2_q;
  assign user_capture_o = cap_dr & user_any;
  assign user_shift_o = sh_dr & user_any;
  assign user_update_o = upd_dr & user_any;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b0;
      tdi_s2_q <= 1'b0;
    end else begin
      tck_s1_q <= tck_i;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms_i;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi_i;
      tdi_s2_q <= tdi_s1_q;
    end
  end

  // controller and instruction register
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_TLR;
      ir_q <= `BST_IR_IDCODE;
      ir_sh_q <= `BST_IR_CAPTURE;
    end else begin
      if (tck_rise) begin
        st_q <= tap_next(st_q, tms_s2_q);
      end
      if (st_q == S_TLR) begin
        ir_q <= `BST_IR_IDCODE;
      end else if (tck_fall & (st_q == S_UP_IR)) begin
        ir_q <= ir_sh_q;
      end
      if (tck_rise & (st_q == S_CAP_IR)) begin
        ir_sh_q <= `BST_IR_CAPTURE;
      end else if (tck_rise & (st_q == S_SH_IR)) begin
        ir_sh_q <= {tdi_s2_q, ir_sh_q[`BST_IR_W-1:1]};
      end
    end
  end

  // bypass, id, usercode and configuration word registers
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byp_q <= 1'b0;
      dr_q <= {`BST_WORD_W{1'b0}};
      cnt_q <= `BST_CNT_ZERO;
      rd_take_q <= 1'b0;
    end else begin
      rd_take_q <= 1'b0;
      if (cap_dr) begin
        byp_q <= 1'b0;
        cnt_q <= `BST_CNT_ZERO;
        case (sel)
          `BST_SEL_IDCODE: dr_q <= ID_CODE;
          `BST_SEL_USERCODE: dr_q <= usercode_i;
          `BST_SEL_CFG_RD: begin
            dr_q <= cfg_rd_data_i;
            rd_take_q <= 1'b1;
          end
          default: dr_q <= dr_q;
        endcase
      end else if (sh_dr) begin
        byp_q <= tdi_s2_q;
        cnt_q <= cnt_q + `BST_CNT_ONE;
        if (word_end & (sel == `BST_SEL_CFG_RD)) begin
          dr_q <= cfg_rd_data_i;
          rd_take_q <= 1'b1;
        end else begin
          dr_q <= {tdi_s2_q, dr_q[`BST_WORD_W-1:1]};
        end
      end
    end
  end

  // completed write words wait here until the fifo has room
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_v_q <= 1'b0;
      push_d_q <= {`BST_WORD_W{1'b0}};
    end else begin
      if (word_end & (sel == `BST_SEL_CFG_WR)) begin
        push_v_q <= 1'b1;
        push_d_q <= {tdi_s2_q, dr_q[`BST_WORD_W-1:1]};
      end else if (push_v_q & fifo_in_rdy) begin
        push_v_q <= 1'b0;
      end
    end
  end

  always @* begin
    case (sel)
      `BST_SEL_BOUNDARY: dr_so = bsr_so;
      `BST_SEL_IDCODE: dr_so = dr_q[0];
      `BST_SEL_USERCODE: dr_so = dr_q[0];
      `BST_SEL_CFG_RD: dr_so = dr_q[0];
      `BST_SEL_CFG_WR: dr_so = dr_q[0];
      `BST_SEL_USER_ONE: dr_so = user_tdo_one_i;
      `BST_SEL_USER_TWO: dr_so = user_tdo_two_i;
      default: dr_so = byp_q;
    endcase
  end

  // tdo moves on the falling edge and drives only while shifting
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= (st_q == S_SH_DR) | (st_q == S_SH_IR);
      tdo_q <= (st_q == S_SH_IR) ? ir_sh_q[0] : dr_so;
    end
  end

  bst_bsr #(
    .NUM_IO(NUM_IO)
  ) u_bsr (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .capture_i(cap_dr & bsr_sel),
    .shift_i(sh_dr & bsr_sel),
    .update_i(upd_dr & bsr_sel),
    .tdi_i(tdi_s2_q),
    .extest_i(ir_q == `BST_IR_EXTEST),
    .intest_i(ir_q == `BST_IR_INTEST),
    .highz_i(ir_q == `BST_IR_HIGHZ),
    .scan_o(bsr_so),
    .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o),
    .core_out_i(core_out_i),
    .core_oe_i(core_oe_i),
    .core_in_o(core_in_o)
  );

  bst_fifo #(
    .WIDTH(`BST_WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wr_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push_v_q),
    .in_ready_o(fifo_in_rdy),
    .in_data_i(push_d_q),
    .out_valid_o(cfg_wr_valid_o),
    .out_ready_i(cfg_wr_ready_i),
    .out_data_o(cfg_wr_data_o)
  );
endmodule

// [bst_tap_props.sv]
// concurrent checks on the test port pins
`timescale 1ns/10ps
module bst_tap_props (
  input wire clock_i,
  input wire rst_b_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire cfg_done_i,
  input wire cfg_rd_take_o,
  input wire [31:0] cfg_wr_data_o,
  input wire cfg_wr_valid_o,
  input wire cfg_wr_ready_i,
  input wire startup_clk_o,
  input wire tap_reset_o,
  input wire user_sel_one_o,
  input wire user_sel_two_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_user_needs_done: assert property (!cfg_done_i && !$past(cfg_done_i) |->
    !user_sel_one_o && !user_sel_two_o) else $error("user chain selected too early");
  a_user_sel_excl: assert property ((user_sel_one_o || user_sel_two_o) |->
    cfg_done_i && !(user_sel_one_o && user_sel_two_o)) else $error("user chain select bad");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i)
    else $error("tdo moved while tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe_o) |-> !tck_i)
    else $error("tdo enable moved while tck high");
  a_startup_pulse: assert property (startup_clk_o |-> tck_i && !tap_reset_o ##1 !startup_clk_o)
    else $error("startup clock pulse malformed");
  a_rd_take_pulse: assert property (cfg_rd_take_o |-> tck_i ##1 !cfg_rd_take_o)
    else $error("readback take pulse malformed");
  a_tlr_entry: assert property ($rose(tap_reset_o) |-> tms_i && tck_i)
    else $error("reset state entered without tms high");
  a_tlr_idle: assert property (tap_reset_o [*2] |->
    !user_sel_one_o && !user_sel_two_o && !tdo_oe_o) else $error("logic active in reset state");
  a_wr_hold: assert property (cfg_wr_valid_o && !cfg_wr_ready_i |=>
    cfg_wr_valid_o && $stable(cfg_wr_data_o)) else $error("write word dropped while stalled");
endmodule
bind bst_tap bst_tap_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .cfg_done_i(cfg_done_i),
  .cfg_rd_take_o(cfg_rd_take_o), .cfg_wr_data_o(cfg_wr_data_o), .cfg_wr_valid_o(cfg_wr_valid_o),
  .cfg_wr_ready_i(cfg_wr_ready_i), .startup_clk_o(startup_clk_o), .tap_reset_o(tap_reset_o),
  .user_sel_one_o(user_sel_one_o), .user_sel_two_o(user_sel_two_o));

// [bst_jtag_ctl.sv]
// scan controller model driving the test link
`timescale 1ns/10ps
module bst_jtag_ctl (
  input wire clock_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire tdo_i
);
  // tck rests low between frames; tdi rests high as on a pulled-up line
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // 84 ns tck, mode and data set one clock_i period after the fall, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    @(negedge clock_i);
    tms_o = m;
    tdi_o = d;
    repeat (10) @(negedge clock_i);
    q = tdo_i;
    tck_o = 1'b1;
    repeat (10) @(negedge clock_i);
    tck_o = 1'b0;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
  // from idle through capture, n shifts lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b1, q);
    if (ir) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
    tick(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
endmodule

// [tb.sv]
// testbench for the boundary scan test port
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] ID = 32'h13579BDF; // arbitrary value
  logic clock_i, rst_b_i, cfg_done_i, cfg_wr_ready_i, u_one, u_two;
  logic [31:0] usercode_i, cfg_rd_data_i;
  logic [3:0] pad_in_i, core_out_i, core_oe_i;
  wire tck, tms, tdi, tdo, rd_take, wr_valid, in_ready, startup, tap_reset, sel_one, sel_two;
  wire tdo_oe, u_tdi, u_cap, u_sh, u_upd;
  // tdo floats outside shift states; the board pulls the line up
  wire tdo_line = tdo_oe ? tdo : 1'b1;
  logic [5:0] u_bits;
  int n_ush, n_ucu, n_take;
  wire [31:0] wr_data;
  wire [3:0] pad_out, pad_oe, core_in;
  int mismatches, total_checks, n_start;
  bst_jtag_ctl u_ctl (.clock_i(clock_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_line));
  bst_tap #(.NUM_IO(4), .ID_CODE(ID), .FIFO_DEPTH(8), .FIFO_AW(3)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .cfg_done_i(cfg_done_i), .usercode_i(usercode_i),
    .cfg_rd_data_i(cfg_rd_data_i), .cfg_rd_take_o(rd_take), .cfg_wr_data_o(wr_data),
    .cfg_wr_valid_o(wr_valid), .cfg_wr_ready_i(cfg_wr_ready_i), .cfg_in_ready_o(in_ready),
    .startup_clk_o(startup), .tap_reset_o(tap_reset), .user_sel_one_o(sel_one),
    .user_sel_two_o(sel_two), .user_tdi_o(u_tdi), .user_capture_o(u_cap), .user_shift_o(u_sh),
    .user_update_o(u_upd), .user_tdo_one_i(u_one), .user_tdo_two_i(u_two), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .core_out_i(core_out_i), .core_oe_i(core_oe_i),
    .core_in_o(core_in));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (startup === 1'b1) n_start++;
  // stand-in for user chain logic: counts strobes and keeps the shifted bits
  always @(posedge clock_i) begin
    if (u_sh === 1'b1) begin
      n_ush++;
      u_bits <= {u_tdi, u_bits[5:1]};
    end
    if (u_cap === 1'b1 || u_upd === 1'b1) n_ucu++;
    if (rd_take === 1'b1) n_take++;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic dr(input int n, input logic [63:0] din, input logic [63:0] exp);
    logic [63:0] q;
    u_ctl.scan(1'b0, n, din, q);
    chk(q, exp);
  endtask
  task automatic ir(input logic [4:0] code);
    logic [63:0] q;
    u_ctl.scan(1'b1, 5, {59'h0, code}, q);
    chk(q, 64'h01);
  endtask
  task automatic t_id();
    chk(tap_reset, 1'b1);
    u_ctl.reset_tap();
    dr(32, 64'h0, {32'h0, ID});
    chk(tdo_oe, 1'b0);
    usercode_i = 32'h2468ACE1;
    ir(5'h08);
    dr(32, 64'h0, 64'h2468ACE1);
  endtask
  // reserved and unconfigured user codes must fall back to the one-bit path
  task automatic t_bypass();
    logic [4:0] codes [5] = '{5'h1F, 5'h1E, 5'h0A, 5'h02, 5'h03};
    core_oe_i = 4'hF;
    foreach (codes[i]) begin
      ir(codes[i]);
      chk(pad_oe, (codes[i] == 5'h0A) ? 4'h0 : 4'hF);
      chk({sel_one, sel_two}, 2'b00);
      dr(8, 64'hA5, 64'h4A);
    end
  endtask
  task automatic t_boundary();
    logic [63:0] e;
    logic [11:0] p;
    logic [3:0] po, pe, ci;
    e = '0;
    p = 12'hC53;
    cfg_done_i = 1'b1; // user chains need this; boundary work ignores it
    pad_in_i = 4'h6;
    core_out_i = 4'hA;
    core_oe_i = 4'h3;
    for (int k = 0; k < 4; k++) begin
      e[3*k] = pad_in_i[k];
      e[3*k+1] = core_out_i[k];
      e[3*k+2] = core_oe_i[k];
      ci[k] = p[3*k];
      po[k] = p[3*k+1];
      pe[k] = p[3*k+2];
    end
    ir(5'h01);
    dr(12, {52'h0, p}, e);
    ir(5'h00);
    chk({pad_out, pad_oe}, {po, pe});
    dr(12, {52'h0, p}, e);
    ir(5'h07);
    chk(core_in, ci);
  endtask
  task automatic t_user();
    u_one = 1'b1;
    u_two = 1'b0;
    ir(5'h02);
    chk({sel_one, sel_two}, 2'b10);
    n_ush = 0;
    n_ucu = 0;
    dr(6, 64'h2D, 64'h3F);
    chk({n_ush, n_ucu}, {32'd6, 32'd2});
    chk(u_bits, 6'h2D);
    ir(5'h03);
    chk({sel_one, sel_two}, 2'b01);
    dr(6, 64'h3F, 64'h0);
    chk(u_bits, 6'h3F);
  endtask
  // consumer stalls until the buffer refuses, then drains with gaps
  task automatic t_cfg();
    logic [63:0] q;
    cfg_wr_ready_i = 1'b0;
    ir(5'h05);
    for (int i = 0; i < 8; i++) u_ctl.scan(1'b0, 32, 64'h5A3C0F00 + i, q);
    chk({wr_valid, in_ready}, 2'b10);
    for (int i = 0; i < 8; i++) begin
      chk(wr_data, 32'h5A3C0F00 + i);
      cfg_wr_ready_i = 1'b1;
      @(negedge clock_i);
      cfg_wr_ready_i = 1'b0;
      repeat (2) @(negedge clock_i);
    end
    chk(wr_valid, 1'b0);
    cfg_rd_data_i = 32'hC3A51E78;
    ir(5'h04);
    n_take = 0;
    dr(32, 64'h0, 64'hC3A51E78);
    chk(n_take, 2);
  endtask
  task automatic t_startup();
    logic q;
    ir(5'h0C);
    n_start = 0;
    repeat (4) u_ctl.tick(1'b0, 1'b1, q);
    chk(n_start, 4);
    u_ctl.reset_tap();
    dr(32, 64'h0, {32'h0, ID});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0;
    cfg_done_i = 1'b0;
    cfg_wr_ready_i = 1'b0;
    u_one = 1'b0;
    u_two = 1'b0;
    usercode_i = 32'h0;
    cfg_rd_data_i = 32'h0;
    pad_in_i = 4'h0;
    core_out_i = 4'h0;
    core_oe_i = 4'h0;
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_id();
    t_bypass();
    t_boundary();
    t_user();
    t_cfg();
    t_startup();
    conclude();
  end
  // about 15000 cycles expected; generous margin before declaring a hang
  initial begin
    repeat (40000) @(posedge clock_i);
    mismatches++;
    conclude();
  end
endmodule
